// *** logic/tpwm_pkg.sv ***
// Package for the two-channel timer PWM block: register offsets, field positions,
// reset values and timing figures.
// Assumes an 8-bit register port with one-cycle read latency.
package tpwm_pkg;
   // Register offsets
   localparam logic [3:0] TPWM_OFS_TIMER_CTRL_STAT = 4'h0;
   localparam logic [3:0] TPWM_OFS_COUNT_HI = 4'h1;
   localparam logic [3:0] TPWM_OFS_COUNT_LO = 4'h2;
   localparam logic [3:0] TPWM_OFS_MOD_HI = 4'h3;
   localparam logic [3:0] TPWM_OFS_MOD_LO = 4'h4;
   localparam logic [3:0] TPWM_OFS_CHAN0_CTRL_STAT = 4'h5;
   localparam logic [3:0] TPWM_OFS_CH0_HI = 4'h6;
   localparam logic [3:0] TPWM_OFS_CH0_LO = 4'h7;
   localparam logic [3:0] TPWM_OFS_CHAN1_CTRL_STAT = 4'h8;
   localparam logic [3:0] TPWM_OFS_CH1_HI = 4'h9;
   localparam logic [3:0] TPWM_OFS_CH1_LO = 4'ha;
   // Timer control/status fields
   localparam int TPWM_TS_OVF = 7;
   localparam int TPWM_TS_OVIE = 6;
   localparam int TPWM_TS_HALT = 5;
   localparam int TPWM_TS_CRST = 4;
   localparam int TPWM_TS_PS_LSB = 0;
   localparam logic [7:0] TPWM_TS_RESET = 8'h20;
   // Channel control/status fields
   localparam int TPWM_CS_FLAG = 7;
   localparam int TPWM_CS_IE = 6;
   localparam int TPWM_CS_MSB = 5;
   localparam int TPWM_CS_MSA = 4;
   localparam int TPWM_CS_ELSB = 3;
   localparam int TPWM_CS_ELSA = 2;
   localparam int TPWM_CS_TOV = 1;
   localparam int TPWM_CS_MAX = 0;
   localparam logic [7:0] TPWM_CS_RESET = 8'h00;
   localparam logic [15:0] TPWM_MOD_RESET = 16'hffff;
   localparam logic [15:0] TPWM_CH_RESET = 16'h0000;
   // Prescaler
   localparam int TPWM_PS_MAX_CODE = 6;
   localparam logic [2:0] TPWM_PS_NONE = 3'h7;
endpackage : tpwm_pkg

// *** logic/tpwm_prescaler.sv ***
// Prescaler: one-cycle tick at bus clock divided by 2^code, codes 0 to 6.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/10ps
module tpwm_prescaler #(
   parameter int DIV_BITS = 6
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Control
   input wire logic run_in,
   input wire logic clear_in,
   input wire logic [2:0] prescale_select_in,
   // Tick
   output logic tick_out
);
   logic [DIV_BITS-1:0] div_q;
   logic [DIV_BITS-1:0] mask;

   assign mask = DIV_BITS'((1 << prescale_select_in) - 1);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || clear_in) begin
         div_q <= '0;
      end else if (run_in) begin
         div_q <= div_q + 1'b1;
      end
   end

   // Code 7 gives no clock at all
   assign tick_out = run_in && (prescale_select_in != tpwm_pkg::TPWM_PS_NONE)
                     && ((div_q & mask) == mask);
endmodule : tpwm_prescaler

// *** logic/tpwm_channel.sv ***
// One timer channel: compare match, output level and event flag.
// Assumes count, tick and flag clear requests come from the same clock.
`timescale 1ns/10ps
module tpwm_channel (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Timer state
   input wire logic tick_in,
   input wire logic overflow_in,
   input wire logic [15:0] count_in,
   input wire logic [15:0] compare_in,
   // Setup
   input wire logic enable_in,
   input wire logic [1:0] edge_level_sel_in,
   input wire logic toggle_on_overflow_in,
   input wire logic full_duty_select_in,
   input wire logic initial_low_in,
   input wire logic flag_clear_in,
   // Results
   output logic pin_out,
   output logic channel_event_flag_out
);
   logic match;
   logic pin_q;
   logic flag_q;

   // Compare against the live value: no hidden latch, so late writes miss
   assign match = enable_in && tick_in && (count_in == compare_in);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pin_q <= 1'b0;
      end else if (!enable_in) begin
         pin_q <= ~initial_low_in;
      end else if (toggle_on_overflow_in && full_duty_select_in) begin
         pin_q <= ~edge_level_sel_in[0];
      end else if (match) begin
         case (edge_level_sel_in)
            2'h1: pin_q <= ~pin_q;
            2'h2: pin_q <= 1'b0;
            2'h3: pin_q <= 1'b1;
            default: pin_q <= pin_q;
         endcase
      end else if (tick_in && overflow_in && toggle_on_overflow_in) begin
         pin_q <= ~pin_q;
      end
      // No overflow toggle without the enable, so output holds ~initial_low_in
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flag_q <= 1'b0;
      end else if (match) begin
         flag_q <= 1'b1;
      end else if (flag_clear_in) begin
         flag_q <= 1'b0;
      end
   end

   assign pin_out = pin_q;
   assign channel_event_flag_out = flag_q;
endmodule : tpwm_channel

// *** logic/tpwm_top.sv ***
// Two-channel timer PWM block with optional buffered pairing of channels 0 and 1.
// Assumes a same-clock register port and same-clock mode inputs.
`timescale 1ns/10ps
module tpwm_top #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [7:0] reg_rdata_out,
   // System state
   input wire logic wait_mode_in,
   input wire logic stop_mode_in,
   input wire logic break_active_in,
   input wire logic break_clear_enable_in,
   // Pins
   output logic chan0_pin_out,
   output logic chan0_pin_oe_out,
   output logic chan1_pin_out,
   output logic chan1_pin_oe_out,
   // Interrupt requests
   output logic overflow_irq_out,
   output logic [CHANNELS-1:0] channel_irq_out
);
   logic [7:0] timer_ctrl_stat_q;
   logic [15:0] counter_q;
   logic [15:0] period_modulo_q;
   logic [7:0] mod_hi_q;
   logic mod_pending_q;
   logic [7:0] cnt_lo_latch_q;
   logic cnt_latched_q;
   logic [7:0] chan_cs_q [CHANNELS];
   logic [15:0] chan_cmp_q [CHANNELS];
   logic [7:0] cmp_hi_q [CHANNELS];
   logic [CHANNELS-1:0] cmp_pending_q;
   logic ovf_armed_q;
   logic [CHANNELS-1:0] ch_armed_q;
   logic active_sel_q;
   logic next_sel_q;
   logic [7:0] rdata_q;
   logic run;
   logic tick;
   logic at_modulo;
   logic overflow_evt;
   logic clr_allowed;
   logic crst;
   logic ovf_clear;
   logic pair_buffer_mode;
   logic [15:0] ch0_compare;
   logic [CHANNELS-1:0] ch_flag;
   logic [CHANNELS-1:0] ch_clear;
   logic [CHANNELS-1:0] ch_pin;
   logic ts_write;
   logic ts_read;

   assign ts_write = reg_write_in && (reg_addr_in == tpwm_pkg::TPWM_OFS_TIMER_CTRL_STAT);
   assign ts_read = reg_read_in && (reg_addr_in == tpwm_pkg::TPWM_OFS_TIMER_CTRL_STAT);
   assign crst = ts_write && reg_wdata_in[tpwm_pkg::TPWM_TS_CRST];
   // Halted by software stop, stop mode or break; wait mode keeps running
   assign run = !timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_HALT] && !stop_mode_in
                && !break_active_in;
   // Break blocks flag clears unless enabled
   assign clr_allowed = !break_active_in || break_clear_enable_in;
   assign pair_buffer_mode = chan_cs_q[0][tpwm_pkg::TPWM_CS_MSB];

   tpwm_prescaler #(
      .DIV_BITS(6)
   ) u_prescaler (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .run_in(run),
      .clear_in(crst),
      .prescale_select_in(timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_PS_LSB +: 3]),
      .tick_out(tick)
   );

   assign at_modulo = (counter_q == period_modulo_q);
   // Overflow held off while modulo high byte awaits its low byte
   assign overflow_evt = tick && at_modulo && !mod_pending_q;

   // Counter: wraps to zero on the tick after modulo, giving modulo+1 ticks
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || crst) begin
         counter_q <= 16'h0000;
      end else if (tick) begin
         counter_q <= at_modulo ? 16'h0000 : counter_q + 16'h0001;
      end
   end

   // Modulo, written high then low
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         period_modulo_q <= tpwm_pkg::TPWM_MOD_RESET;
         mod_hi_q <= 8'h00;
         mod_pending_q <= 1'b0;
      end else if (reg_write_in && reg_addr_in == tpwm_pkg::TPWM_OFS_MOD_HI) begin
         mod_hi_q <= reg_wdata_in;
         mod_pending_q <= 1'b1;
      end else if (reg_write_in && reg_addr_in == tpwm_pkg::TPWM_OFS_MOD_LO) begin
         period_modulo_q <= {mod_pending_q ? mod_hi_q : period_modulo_q[15:8],
                             reg_wdata_in};
         mod_pending_q <= 1'b0;
      end
   end

   // Overflow clear is a read-with-flag then write-zero; arming survives break
   assign ovf_clear = ts_write && !reg_wdata_in[tpwm_pkg::TPWM_TS_OVF] && ovf_armed_q
                      && clr_allowed;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         timer_ctrl_stat_q <= tpwm_pkg::TPWM_TS_RESET;
      end else begin
         if (ts_write) begin
            timer_ctrl_stat_q[6:0] <= {reg_wdata_in[6:5], 1'b0, 1'b0, reg_wdata_in[2:0]};
         end
         if (overflow_evt) begin
            timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_OVF] <= 1'b1;
         end else if (ovf_clear) begin
            timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_OVF] <= 1'b0;
         end
      end
   end

   // A new event disarms the pending clear so it cannot be lost
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ovf_armed_q <= 1'b0;
      end else if (overflow_evt || ovf_clear) begin
         ovf_armed_q <= 1'b0;
      end else if (ts_read && timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_OVF] && clr_allowed) begin
         ovf_armed_q <= 1'b1;
      end
   end

   // Channel registers
   for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      localparam logic [3:0] CS_OFS = (c == 0) ? tpwm_pkg::TPWM_OFS_CHAN0_CTRL_STAT
                                               : tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT;
      localparam logic [3:0] HI_OFS = (c == 0) ? tpwm_pkg::TPWM_OFS_CH0_HI
                                               : tpwm_pkg::TPWM_OFS_CH1_HI;
      localparam logic [3:0] LO_OFS = (c == 0) ? tpwm_pkg::TPWM_OFS_CH0_LO
                                               : tpwm_pkg::TPWM_OFS_CH1_LO;
      logic cs_wr;
      logic cs_rd;
      logic ignored;

      // Channel 1 control ignored while paired
      assign ignored = (c != 0) && pair_buffer_mode;
      assign cs_wr = reg_write_in && reg_addr_in == CS_OFS && !ignored;
      assign cs_rd = reg_read_in && reg_addr_in == CS_OFS && !ignored;
      assign ch_clear[c] = cs_wr && !reg_wdata_in[tpwm_pkg::TPWM_CS_FLAG] && ch_armed_q[c]
                           && clr_allowed;

      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            chan_cs_q[c] <= tpwm_pkg::TPWM_CS_RESET;
         end else if (cs_wr) begin
            // Buffer bit only exists on channel 0
            chan_cs_q[c] <= {1'b0, reg_wdata_in[6], (c == 0) ? reg_wdata_in[5] : 1'b0,
                             reg_wdata_in[4:0]};
         end
      end

      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            ch_armed_q[c] <= 1'b0;
         // A fresh compare disarms a pending clear, so no request is lost
         end else if (ch_clear[c] || (tick && g_unit[c].en
                      && counter_q == ((c == 0) ? ch0_compare : chan_cmp_q[c]))) begin
            ch_armed_q[c] <= 1'b0;
         end else if (cs_rd && ch_flag[c] && clr_allowed) begin
            ch_armed_q[c] <= 1'b1;
         end
      end

      // Compare value, latched whole on low byte; unpaired, a write goes live at once
      always_ff @(posedge clk_in) begin
         if (!rst_n_in) begin
            chan_cmp_q[c] <= tpwm_pkg::TPWM_CH_RESET;
            cmp_hi_q[c] <= 8'h00;
            cmp_pending_q[c] <= 1'b0;
         end else if (reg_write_in && reg_addr_in == HI_OFS) begin
            cmp_hi_q[c] <= reg_wdata_in;
            cmp_pending_q[c] <= 1'b1;
         end else if (reg_write_in && reg_addr_in == LO_OFS) begin
            chan_cmp_q[c] <= {cmp_pending_q[c] ? cmp_hi_q[c] : chan_cmp_q[c][15:8],
                              reg_wdata_in};
            cmp_pending_q[c] <= 1'b0;
         end
      end

      assign channel_irq_out[c] = ch_flag[c] && chan_cs_q[c][tpwm_pkg::TPWM_CS_IE];
   end

   // Buffered pair: track last-written pair, swap at overflow
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !pair_buffer_mode) begin
         next_sel_q <= 1'b0;
      end else if (reg_write_in && (reg_addr_in == tpwm_pkg::TPWM_OFS_CH1_LO
                                    || reg_addr_in == tpwm_pkg::TPWM_OFS_CH1_HI)) begin
         next_sel_q <= 1'b1;
      end else if (reg_write_in && (reg_addr_in == tpwm_pkg::TPWM_OFS_CH0_LO
                                    || reg_addr_in == tpwm_pkg::TPWM_OFS_CH0_HI)) begin
         next_sel_q <= 1'b0;
      end
   end

   // Channel 0 pair controls first after linking
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !pair_buffer_mode) begin
         active_sel_q <= 1'b0;
      end else if (overflow_evt) begin
         active_sel_q <= next_sel_q;
      end
   end

   assign ch0_compare = (pair_buffer_mode && active_sel_q) ? chan_cmp_q[1] : chan_cmp_q[0];

   // Channel logic; a channel is live with edge/level non-zero, channel 1 only while unpaired
   for (genvar c = 0; c < CHANNELS; c++) begin : g_unit
      logic en;
      assign en = (c == 0 || !pair_buffer_mode) &&
                  (chan_cs_q[c][tpwm_pkg::TPWM_CS_ELSB] || chan_cs_q[c][tpwm_pkg::TPWM_CS_ELSA]);
      tpwm_channel u_channel (
         .clk_in(clk_in),
         .rst_n_in(rst_n_in),
         .tick_in(tick),
         .overflow_in(at_modulo),
         .count_in(counter_q),
         .compare_in((c == 0) ? ch0_compare : chan_cmp_q[c]),
         .enable_in(en),
         .edge_level_sel_in(chan_cs_q[c][tpwm_pkg::TPWM_CS_ELSA +: 2]),
         .toggle_on_overflow_in(chan_cs_q[c][tpwm_pkg::TPWM_CS_TOV]),
         .full_duty_select_in(chan_cs_q[c][tpwm_pkg::TPWM_CS_MAX]),
         .initial_low_in(chan_cs_q[c][tpwm_pkg::TPWM_CS_MSA]),
         .flag_clear_in(ch_clear[c]),
         .pin_out(ch_pin[c]),
         .channel_event_flag_out(ch_flag[c])
      );
   end

   // Counter high-byte read latches low byte
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cnt_lo_latch_q <= 8'h00;
         cnt_latched_q <= 1'b0;
      end else if (reg_read_in && reg_addr_in == tpwm_pkg::TPWM_OFS_COUNT_HI
                   && !cnt_latched_q) begin
         cnt_lo_latch_q <= counter_q[7:0];
         cnt_latched_q <= 1'b1;
      end else if (reg_read_in && reg_addr_in == tpwm_pkg::TPWM_OFS_COUNT_LO) begin
         cnt_latched_q <= 1'b0;
      end
   end

   // Read data, one cycle later; unmapped reads zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (reg_read_in) begin
         if (reg_addr_in == tpwm_pkg::TPWM_OFS_TIMER_CTRL_STAT) begin
            rdata_q <= timer_ctrl_stat_q;
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_COUNT_HI) begin
            rdata_q <= counter_q[15:8];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_COUNT_LO) begin
            rdata_q <= cnt_latched_q ? cnt_lo_latch_q : counter_q[7:0];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_MOD_HI) begin
            rdata_q <= period_modulo_q[15:8];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_MOD_LO) begin
            rdata_q <= period_modulo_q[7:0];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CHAN0_CTRL_STAT) begin
            rdata_q <= {ch_flag[0], chan_cs_q[0][6:0]};
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CH0_HI) begin
            rdata_q <= chan_cmp_q[0][15:8];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CH0_LO) begin
            rdata_q <= chan_cmp_q[0][7:0];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT) begin
            rdata_q <= {ch_flag[1], chan_cs_q[1][6:0]};
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CH1_HI) begin
            rdata_q <= chan_cmp_q[1][15:8];
         end else if (reg_addr_in == tpwm_pkg::TPWM_OFS_CH1_LO) begin
            rdata_q <= chan_cmp_q[1][7:0];
         end else begin
            rdata_q <= 8'h00;
         end
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;
   // Requests stay live in wait mode, so they can wake the core
   assign overflow_irq_out = timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_OVF]
                             && timer_ctrl_stat_q[tpwm_pkg::TPWM_TS_OVIE];
   assign chan0_pin_out = ch_pin[0];
   assign chan0_pin_oe_out = g_unit[0].en;
   assign chan1_pin_out = ch_pin[1];
   // Pin released to general I/O while paired
   assign chan1_pin_oe_out = g_unit[1].en;
endmodule : tpwm_top

// *** sim/tpwm_checker.sv ***
// Concurrent checks on the timer PWM top module ports.
// Assumes one clock domain and shadows only the control bits it needs.
`timescale 1ns/10ps
module tpwm_checker #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [7:0] reg_rdata_out,
   // System state
   input wire logic stop_mode_in,
   input wire logic break_active_in,
   // Pins and requests
   input wire logic chan0_pin_out,
   input wire logic chan0_pin_oe_out,
   input wire logic chan1_pin_oe_out,
   input wire logic overflow_irq_out,
   input wire logic [CHANNELS-1:0] channel_irq_out
);
   logic [6:0] cs0_q;
   logic [6:0] cs1_q;
   logic ts_ie_q;
   logic [9:0] quiet_q;
   // Shadow of control bits
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         cs0_q <= 7'h00;
         cs1_q <= 7'h00;
         ts_ie_q <= 1'b0;
      end else if (reg_write_in) begin
         if (reg_addr_in == tpwm_pkg::TPWM_OFS_CHAN0_CTRL_STAT) begin
            cs0_q <= reg_wdata_in[6:0];
         end
         if (reg_addr_in == tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT && !cs0_q[5]) begin
            cs1_q <= reg_wdata_in[6:0];
         end
         if (reg_addr_in == tpwm_pkg::TPWM_OFS_TIMER_CTRL_STAT) begin
            ts_ie_q <= reg_wdata_in[6];
         end
      end
   end
   // Cycles since last write
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || reg_write_in) begin
         quiet_q <= 10'h000;
      end else if (quiet_q != 10'h3ff) begin
         quiet_q <= quiet_q + 10'h001;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   read_idle_a: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside slot");
   unmapped_read_a: assert property (reg_read_in && reg_addr_in > 4'ha
      |=> reg_rdata_out == 8'h00) else $error("unmapped read");
   ovf_gate_a: assert property (overflow_irq_out |-> ts_ie_q)
      else $error("overflow request while disabled");
   ch0_gate_a: assert property (channel_irq_out[0] |-> cs0_q[6])
      else $error("channel 0 request while disabled");
   ch1_gate_a: assert property (channel_irq_out[1] |-> cs1_q[6])
      else $error("channel 1 request while disabled");
   ch1_release_a: assert property (chan1_pin_oe_out ==
      (!cs0_q[5] && cs1_q[3:2] != 2'h0)) else $error("channel 1 pin enable wrong");
   ch0_drive_a: assert property (chan0_pin_oe_out == (cs0_q[3:2] != 2'h0))
      else $error("channel 0 pin enable wrong");
   zero_duty_a: assert property (quiet_q >= 10'h258 && !cs0_q[1] && cs0_q[3]
      |-> chan0_pin_out == cs0_q[2]) else $error("pin moved without overflow toggle");
   full_duty_a: assert property (quiet_q >= 10'h258 && cs0_q[1] && cs0_q[0] && cs0_q[3]
      |-> chan0_pin_out == !cs0_q[2]) else $error("full duty level wrong");
   halt_ovf_a: assert property ($rose(overflow_irq_out) && !$past(reg_write_in) |->
      !(($past(stop_mode_in) || $past(break_active_in)) &&
        ($past(stop_mode_in, 2) || $past(break_active_in, 2))))
      else $error("overflow while halted");
endmodule : tpwm_checker

bind tpwm_top tpwm_checker #(.CHANNELS(CHANNELS)) u_checker (
   .clk_in,
   .rst_n_in,
   .reg_addr_in,
   .reg_wdata_in,
   .reg_write_in,
   .reg_read_in,
   .reg_rdata_out,
   .stop_mode_in,
   .break_active_in,
   .chan0_pin_out,
   .chan0_pin_oe_out,
   .chan1_pin_oe_out,
   .overflow_irq_out,
   .channel_irq_out
);

// *** sim/tpwm_pin_monitor.sv ***
// Load on the channel 0 pin: measures period and high time between rising edges.
// Assumes a pull-down on the pin while the block does not drive it.
`timescale 1ns/10ps
module tpwm_pin_monitor (
   // Clock
   input wire logic clk_in,
   // Pin
   input wire logic pin_in,
   input wire logic pin_oe_in,
   // Measurements
   output logic [15:0] period_out,
   output logic [15:0] high_out,
   output logic [7:0] rises_out
);
   logic level;
   logic level_q;
   logic [15:0] per_q;
   logic [15:0] hi_q;
   assign level = pin_oe_in & pin_in;
   initial {level_q, per_q, hi_q, period_out, high_out, rises_out} = '0;
   always @(posedge clk_in) begin
      level_q <= level;
      if (level && !level_q) begin
         period_out <= per_q;
         high_out <= hi_q;
         rises_out <= rises_out + 8'h01;
         per_q <= 16'h0001;
         hi_q <= 16'h0001;
      end else begin
         per_q <= per_q + 16'h0001;
         hi_q <= hi_q + {15'h0000, level};
      end
   end
endmodule : tpwm_pin_monitor

// *** sim/testbench.sv ***
// Self-checking bench for the timer PWM block with a pin load model.
// Assumes the checker is bound to the top module by its own file.
`timescale 1ns/10ps
module testbench;
   logic clk_in, rst_n_in, reg_write_in, reg_read_in, chan0_pin_out, chan0_pin_oe_out;
   logic wait_mode_in, stop_mode_in, break_active_in, break_clear_enable_in;
   logic chan1_pin_out, chan1_pin_oe_out, overflow_irq_out;
   logic [3:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, rises, rv, cs;
   logic [1:0] channel_irq_out;
   logic [15:0] per, hi, m, c, a, b;
   logic [31:0] seed;
   int n_mismatch, samples_checked, i;
   localparam logic [3:0] TS_OFS = tpwm_pkg::TPWM_OFS_TIMER_CTRL_STAT;
   localparam logic [3:0] C0_OFS = tpwm_pkg::TPWM_OFS_CHAN0_CTRL_STAT;
   tpwm_top DUT (.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
      .reg_rdata_out, .wait_mode_in, .stop_mode_in, .break_active_in, .break_clear_enable_in,
      .chan0_pin_out, .chan0_pin_oe_out, .chan1_pin_out, .chan1_pin_oe_out, .overflow_irq_out,
      .channel_irq_out);
   tpwm_pin_monitor u_load (.clk_in(clk_in), .pin_in(chan0_pin_out),
      .pin_oe_in(chan0_pin_oe_out), .period_out(per), .high_out(hi), .rises_out(rises));
   function automatic int unsigned rnd(input int unsigned n);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed % n;
   endfunction : rnd
   function automatic logic [15:0] exp_high(input logic [15:0] m, c,
      input int ps, input logic set_mode);
      logic [15:0] p;
      p = (c + 16'h0001) << ps;
      return set_mode ? ((m + 16'h0001) << ps) - p : p;
   endfunction : exp_high
   function automatic logic [7:0] exp_reset(input logic [3:0] a);
      if (a == TS_OFS) return tpwm_pkg::TPWM_TS_RESET;
      if (a == tpwm_pkg::TPWM_OFS_MOD_HI || a == tpwm_pkg::TPWM_OFS_MOD_LO) return 8'hff;
      return 8'h00;
   endfunction : exp_reset
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_write_in <= 1'b1;
      @(posedge clk_in);
      reg_write_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk_in);
      reg_addr_in <= ad;
      reg_read_in <= 1'b1;
      @(posedge clk_in);
      reg_read_in <= 1'b0;
      @(posedge clk_in);
      d = reg_rdata_out;
   endtask : rd
   task automatic rd_cnt(output logic [15:0] v);
      rd(tpwm_pkg::TPWM_OFS_COUNT_HI, v[15:8]);
      rd(tpwm_pkg::TPWM_OFS_COUNT_LO, v[7:0]);
   endtask : rd_cnt
   task automatic wait_for(input int sel, input int n);
      int k;
      logic [7:0] start;
      start = rises;
      for (k = 0; k < 20000; k++) begin
         if (sel == 0 && rises == start + 8'(n)) break;
         if (sel == 1 && overflow_irq_out === 1'b1) break;
         if (sel == 2 && channel_irq_out[0] === 1'b1) break;
         @(posedge clk_in);
      end
      if (k == 20000) begin
         n_mismatch++;
         $display("MISMATCH t=%0t wait ran out", $time);
         end_of_test();
      end
   endtask : wait_for
   task automatic pwm_setup(input logic [2:0] ps, input logic [15:0] m, c,
      input logic [7:0] cs);
      wr(TS_OFS, 8'h30);
      wr(tpwm_pkg::TPWM_OFS_MOD_HI, m[15:8]);
      wr(tpwm_pkg::TPWM_OFS_MOD_LO, m[7:0]);
      wr(tpwm_pkg::TPWM_OFS_CH0_HI, c[15:8]);
      wr(tpwm_pkg::TPWM_OFS_CH0_LO, c[7:0]);
      wr(C0_OFS, cs);
      wr(TS_OFS, {5'h00, ps});
   endtask : pwm_setup
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      {rst_n_in, reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} = '0;
      {wait_mode_in, stop_mode_in, break_active_in, break_clear_enable_in} = 4'h0;
      n_mismatch = 0;
      samples_checked = 0;
      seed = 32'h00000061;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      wr(4'hf, 8'h5a);
      for (i = 0; i < 16; i++) begin
         rd(4'(i), rv);
         chk_val(16'(rv), 16'(exp_reset(4'(i))));
      end
      for (i = 0; i <= tpwm_pkg::TPWM_PS_MAX_CODE; i++) begin
         m = 16'(3 + rnd(16));
         c = 16'(rnd(m));
         cs = rnd(2) ? 8'h1e : 8'h1a;
         pwm_setup(3'(i), m, c, cs);
         wait_mode_in <= 1'(rnd(2));
         wait_for(0, 3);
         chk_val(per, (m + 16'h0001) << i);
         chk_val(hi, exp_high(m, c, i, cs[2]));
         wait_mode_in <= 1'b0;
         c = 16'(rnd(m));
         wr(tpwm_pkg::TPWM_OFS_CH0_LO, c[7:0]);
         wait_for(0, 4);
         chk_val(hi, exp_high(m, c, i, cs[2]));
      end
      pwm_setup(3'h0, 16'h00ff, 16'h0080, 8'h1a);
      wait_for(0, 3);
      chk_val(per, 16'h0100);
      chk_val(hi, 16'h0081);
      wr(C0_OFS, 8'h18);
      repeat (600) @(posedge clk_in);
      chk_val(16'(chan0_pin_out), 16'h0000);
      wr(C0_OFS, 8'h1b);
      repeat (600) @(posedge clk_in);
      chk_val(16'(chan0_pin_out), 16'h0001);
      wr(TS_OFS, 8'h40);
      wait_for(1, 0);
      wr(C0_OFS, 8'h5a);
      wait_for(2, 0);
      // Halted so no fresh event can race the two-step clear
      wr(TS_OFS, 8'h20);
      @(posedge clk_in);
      chk_val(16'(overflow_irq_out), 16'h0000);
      rd(TS_OFS, rv);
      break_active_in <= 1'b1;
      wr(TS_OFS, 8'h20);
      rd(TS_OFS, rv);
      chk_val(16'(rv), 16'h00a0);
      break_active_in <= 1'b0;
      wr(TS_OFS, 8'h20);
      rd(TS_OFS, rv);
      chk_val(16'(rv), 16'h0020);
      rd(C0_OFS, rv);
      break_active_in <= 1'b1;
      break_clear_enable_in <= 1'b1;
      wr(C0_OFS, 8'h5a);
      rd(C0_OFS, rv);
      chk_val(16'(rv), 16'h005a);
      {break_active_in, break_clear_enable_in} <= 2'h0;
      wr(TS_OFS, 8'h00);
      for (i = 0; i < 2; i++) begin
         if (i == 0) stop_mode_in <= 1'b1;
         else break_active_in <= 1'b1;
         rd_cnt(a);
         repeat (40) @(posedge clk_in);
         rd_cnt(b);
         chk_val(b, a);
         {stop_mode_in, break_active_in} <= 2'h0;
         rd_cnt(b);
         chk_val(16'(b != a), 16'h0001);
      end
      wr(tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT, 8'h1a);
      pwm_setup(3'h0, 16'h003f, 16'h0009, 8'h2a);
      wait_for(0, 3);
      chk_val(hi, 16'h000a);
      chk_val(16'(chan1_pin_oe_out), 16'h0000);
      wr(tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT, 8'h00);
      rd(tpwm_pkg::TPWM_OFS_CHAN1_CTRL_STAT, rv);
      chk_val(16'(rv), 16'h001a);
      wr(tpwm_pkg::TPWM_OFS_CH1_HI, 8'h00);
      wr(tpwm_pkg::TPWM_OFS_CH1_LO, 8'h1d);
      wait_for(0, 3);
      chk_val(hi, 16'h001e);
      wr(tpwm_pkg::TPWM_OFS_CH0_HI, 8'h00);
      wr(tpwm_pkg::TPWM_OFS_CH0_LO, 8'h04);
      wait_for(0, 3);
      chk_val(hi, 16'h0005);
      end_of_test();
   end
endmodule : testbench
